// *** src/pdwl_top.sv ***
// write lock for the peripheral-disable registers
module pdwl_top
  import pdwl_pkg::*;
#(
  parameter int unsigned NREGS = PDWL_NUM_REGS,
  parameter int unsigned W = PDWL_REG_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic unlocked,
  input wire logic [PDWL_CFG_W-1:0] boot_config_word_three,
  input wire logic cfg_wr,
  input wire logic [PDWL_CFG_W-1:0] cfg_wdata,
  input wire logic [NREGS-1:0] pmd_wr,
  input wire logic [W-1:0] pmd_wdata,
  input wire logic pin_select_wr,
  output logic [NREGS*W-1:0] periph_disable_regs,
  output logic disable_reg_lock,
  output logic one_way_held,
  output logic unlock_allowed,
  output logic pin_select_wr_ok,
  output logic wr_ack
);
  logic lock_q;
  logic lock_d;
  logic one_way;
  logic set_try;
  logic armed_q;
  logic armed_d;

  // config word is static after boot; read directly
  assign one_way = boot_config_word_three[PDWL_ONE_WAY_BIT];
  assign set_try = cfg_wdata[PDWL_LOCK_BIT];
  // reset value of the lock is not a software set, so one session is left
  assign one_way_held = one_way && armed_q && lock_q;

  always_comb begin
    lock_d = lock_q;
    if (cfg_wr && unlocked) begin
      // sticky: once set with one-way, no write clears it until reset drops armed_q
      if (!one_way_held) begin
        lock_d = set_try;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= PDWL_LOCK_RST;
    end else if (clk_en) begin
      lock_q <= lock_d;
    end
  end

  // remembers a software set of the lock until the next reset
  always_comb begin
    armed_d = armed_q;
    if (cfg_wr && unlocked && set_try) begin
      armed_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= PDWL_ARMED_RST;
    end else if (clk_en) begin
      armed_q <= armed_d;
    end
  end

  assign disable_reg_lock = lock_q;
  assign unlock_allowed = unlocked && !one_way_held;
  assign pin_select_wr_ok = pin_select_wr && !one_way_held;
  // every pmd or cfg write acks while clk_en is high, locked or not
  assign wr_ack = clk_en && (|pmd_wr || cfg_wr);

  genvar gi;
  generate
    for (gi = 0; gi < NREGS; gi++) begin : g_reg
      pdwl_reg_slot #(.W(W)) u_slot (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .wr_en(pmd_wr[gi]),
        .locked(lock_q),
        .wdata(pmd_wdata),
        .value(periph_disable_regs[gi*W +: W])
      );

      chk_slot_locked: assert property (
        @(posedge clk) disable iff (!arst_n)
        (clk_en && lock_q && pmd_wr[gi]) |=>
          $stable(periph_disable_regs[gi*W +: W]))
        else $error("locked write changed a slot");

      chk_slot_reset: assert property (
        @(posedge clk) $rose(arst_n) |->
          periph_disable_regs[gi*W +: W] == W'(PDWL_PMD_RST))
        else $error("slot not cleared by reset");
    end
  endgenerate

  chk_lock_blocks_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && lock_q && pmd_wr[0]) |=>
      $stable(periph_disable_regs[W-1:0]))
    else $error("locked write changed a register");

  chk_open_write_lands: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && !lock_q && pmd_wr[0]) |=>
      periph_disable_regs[W-1:0] == $past(pmd_wdata))
    else $error("unlocked write lost");

  chk_write_acks: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && pmd_wr[0]) |-> wr_ack)
    else $error("write not acknowledged");

  chk_unlock_needed: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!unlocked || !cfg_wr) |=> $stable(lock_q))
    else $error("lock moved without unlock");

  chk_one_way_sticky: assert property (
    @(posedge clk) disable iff (!arst_n)
    one_way_held |=> lock_q)
    else $error("one-way lock cleared");

  chk_pin_select_block: assert property (
    @(posedge clk) disable iff (!arst_n)
    one_way_held |-> (!pin_select_wr_ok && !unlock_allowed))
    else $error("pin-select open under one-way");

  chk_sticky_holds: assert property (
    @(posedge clk) disable iff (!arst_n)
    (one_way_held && cfg_wr && unlocked && !set_try) |=> lock_q)
    else $error("sticky lock cleared by write");

  chk_reset_locked: assert property (
    @(posedge clk) $rose(arst_n) |-> lock_q)
    else $error("lock not set after reset");

  chk_ack_idle: assert property (
    @(posedge clk) disable iff (!arst_n)
    !(|pmd_wr || cfg_wr) |-> !wr_ack)
    else $error("ack without a write");

  chk_ack_frozen: assert property (
    @(posedge clk) disable iff (!arst_n)
    !clk_en |-> !wr_ack)
    else $error("ack while frozen");

  chk_lock_set_lands: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && cfg_wr && unlocked && set_try) |=> lock_q)
    else $error("unlocked set of lock lost");

  chk_lock_clear_lands: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && cfg_wr && unlocked && !set_try && !one_way_held) |=>
      !lock_q)
    else $error("unlocked clear of lock lost");

  chk_freeze_lock: assert property (
    @(posedge clk) disable iff (!arst_n)
    !clk_en |=> $stable(lock_q))
    else $error("lock moved while frozen");

  chk_freeze_regs: assert property (
    @(posedge clk) disable iff (!arst_n)
    !clk_en |=> $stable(periph_disable_regs))
    else $error("register moved while frozen");

  chk_arm_on_set: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && cfg_wr && unlocked && set_try) |=> armed_q)
    else $error("software set not recorded");

  chk_arm_sticky: assert property (
    @(posedge clk) disable iff (!arst_n)
    armed_q |=> armed_q)
    else $error("set record lost without reset");

  chk_reset_disarmed: assert property (
    @(posedge clk) $rose(arst_n) |-> !one_way_held)
    else $error("one-way hold survived reset");

  chk_unlock_passes: assert property (
    @(posedge clk) disable iff (!arst_n)
    (unlocked && !one_way_held) |-> unlock_allowed)
    else $error("unlock refused without one-way hold");

  chk_pin_select_pass: assert property (
    @(posedge clk) disable iff (!arst_n)
    (pin_select_wr && !one_way_held) |-> pin_select_wr_ok)
    else $error("pin-select write refused wrongly");
endmodule : pdwl_top

// *** src/pdwl_pkg.sv ***
// constants for the peripheral-disable write lock block
package pdwl_pkg;
  localparam int unsigned PDWL_CFG_W = 32;
  localparam int unsigned PDWL_LOCK_BIT = 12;
  localparam int unsigned PDWL_ONE_WAY_BIT = 28;
  localparam int unsigned PDWL_NUM_REGS = 4;
  localparam int unsigned PDWL_REG_W = 32;
  localparam logic PDWL_LOCK_RST = 1'b1;
  localparam logic PDWL_ARMED_RST = 1'b0;
  localparam logic [PDWL_REG_W-1:0] PDWL_PMD_RST = 32'h0000_0000;
endpackage : pdwl_pkg

// *** src/pdwl_reg_slot.sv ***
// one peripheral-disable register guarded by the write lock
module pdwl_reg_slot
  import pdwl_pkg::*;
#(
  parameter int unsigned W = PDWL_REG_W,
  parameter logic [W-1:0] RST = W'(PDWL_PMD_RST)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic locked,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] value
);
  logic [W-1:0] val_q;
  logic [W-1:0] val_d;

  always_comb begin
    val_d = val_q;
    // locked writes vanish silently
    if (wr_en && !locked) begin
      val_d = wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      val_q <= RST;
    end else if (clk_en) begin
      val_q <= val_d;
    end
  end

  assign value = val_q;
endmodule : pdwl_reg_slot

// *** bench/test_pdwl_top.sv ***
// self-checking bench for the disable-register write lock
module test_pdwl_top
  import pdwl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, clk_en = 1, unlocked = 0;
  logic cfg_wr = 0, pin_select_wr = 0;
  logic [31:0] bcw = 0, cfg_wdata = 0, pmd_wdata = 0;
  logic [3:0] pmd_wr = 0;
  logic [127:0] regs;
  logic lock, held, ua, psok, ack;
  int num_errors = 0, n_tests = 0, cyc = 0;
  pdwl_top DUT (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .unlocked(unlocked), .boot_config_word_three(bcw), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .pmd_wr(pmd_wr), .pmd_wdata(pmd_wdata),
    .pin_select_wr(pin_select_wr), .periph_disable_regs(regs),
    .disable_reg_lock(lock), .one_way_held(held), .unlock_allowed(ua),
    .pin_select_wr_ok(psok), .wr_ack(ack));
  always #2.5 clk = ~clk;
  // the whole run needs well under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  task cmp(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one strobe cycle; outputs settle before the next falling edge
  task wr(input logic c, input logic [3:0] p, input logic [31:0] d);
    @(negedge clk);
    cfg_wr = c;
    pmd_wr = p;
    cfg_wdata = d;
    pmd_wdata = d;
    #1 cmp(ack, clk_en);
    @(negedge clk);
    cfg_wr = 0;
    pmd_wr = 0;
  endtask : wr
  task t_default();
    cmp(lock, 1);
    wr(0, 4'h1, 32'ha5a5_5a5a);
    cmp(regs, 0);
  endtask : t_default
  task t_unlock();
    wr(1, 0, 0);
    cmp(lock, 1);
    unlocked = 1;
    clk_en = 0;
    wr(1, 0, 0);
    cmp(lock, 1);
    clk_en = 1;
    wr(1, 0, 0);
    cmp(lock, 0);
    wr(0, 4'h8, 32'h1234_5678);
    cmp(regs, {32'h1234_5678, 96'h0});
    wr(1, 0, 32'h0000_1000);
    wr(0, 4'h8, 32'h0);
    cmp(regs, {32'h1234_5678, 96'h0});
  endtask : t_unlock
  task t_one_way();
    bcw = 32'h1000_0000;
    wr(1, 0, 0);
    cmp(lock, 1);
    cmp(held, 1'b1);
    cmp(ua, 0);
    pin_select_wr = 1;
    #1 cmp(psok, 0);
    pin_select_wr = 0;
    arst_n = 0;
    #1 cmp({lock, regs}, {1'b1, 128'h0});
    @(negedge clk);
    arst_n = 1;
  endtask : t_one_way
  // after reset the one-way option still grants one write session
  task t_reopen();
    cmp(held, 1'b0);
    wr(1'b1, 4'h0, 32'h0000_0000);
    cmp(lock, 1'b0);
    wr(1'b0, 4'h1, 32'hc3c3_3c3c);
    cmp(regs, {96'h0, 32'hc3c3_3c3c});
    cmp(ua, 1'b1);
    pin_select_wr = 1'b1;
    #1 cmp(psok, 1'b1);
    @(negedge clk);
    pin_select_wr = 1'b0;
    wr(1'b1, 4'h0, 32'h0000_1000);
    cmp(held, 1'b1);
    wr(1'b1, 4'h0, 32'h0000_0000);
    cmp(lock, 1'b1);
  endtask : t_reopen
  task finish_test();
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1;
    t_default();
    t_unlock();
    t_one_way();
    t_reopen();
    finish_test();
  end
endmodule : test_pdwl_top
